/* hw/pkt_path_pkg.sv */
// Package of constants and types shared by the packet path design.
package pkt_path_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 2;
  localparam int TXQ_DEPTH = 16;
  localparam int RXQ_DEPTH = 64;
  localparam int SRAM_DEPTH = 256;
  localparam int TXQ_AW = 4;
  localparam int RXQ_AW = 6;
  localparam int SRAM_AW = 8;
  localparam int BURST_WORDS = 4;
  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam int CLK_MHZ = 40;
  localparam int DRAIN_US = 15;
  localparam int DRAIN_CYC = DRAIN_US * CLK_MHZ;
  // ****************************************************************
  // Host access targets
  // ****************************************************************
  localparam logic [1:0] ACC_TXQ = 2'h0;
  localparam logic [1:0] ACC_RXQ = 2'h1;
  localparam logic [1:0] ACC_SRAM = 2'h2;
  localparam logic [1:0] ACC_CFG = 2'h3;
  typedef enum logic [1:0] {ARB_IDLE, ARB_MOVE, ARB_NOTE} arb_state_t;
endpackage : pkt_path_pkg

/* hw/host_mac_packet_path.sv */
// Packet data path between the host bus side and four MAC port queues.
//
// Operation
// [RULE1] Host checks transmit queue free space before starting a send.
// [RULE2] Host drops a packet if space does not appear within its timeout.
// [RULE3] Host programs DMA into a port transmit queue; engine pulses done.
// [RULE4] A two-entry buffer absorbs burst read data before the queues.
// [RULE5] Each port has a deep receive queue.
// [RULE6] Arbiter moves whole packets to SRAM, then notifies the host.
// [RULE7] Host then copies the received packet out of SRAM by DMA.
// [RULE8] Burst write toward host starts only with a burst buffered.
// [RULE9] Host may read and write every port queue by single access; receive queues here can only be read.
// [RULE10] Single 32-bit register reads and writes are supported.
// [RULE11] First packet byte sits in lanes 7:0, later bytes ascend.
// [RULE12] Optional byte swap on packet data in both directions.
// [RULE13] Last word flag only on the final word, bytes in low lanes.
// [RULE14] No word endian conversion is applied inside the datapath.
// [RULE15] User mode maps virtual MAC numbers onto the one active port.
// [RULE16] User mode permits only single accesses; DMA is refused.
// [RULE17] Crossings stay in the host bridge; this block has one clock.
// [RULE18] Configuration words stream out over a FIFO-like write port.
// [RULE19] Receive arbiter grants ports round robin, one packet per grant.
`timescale 1ns/1ps
module host_mac_packet_path
  import pkt_path_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_swap_en,
  input wire logic i_user_mode,
  input wire logic [2:0] i_vmac,
  // DMA write stream from host into a transmit queue.
  input wire logic i_tx_valid,
  input wire logic [31:0] i_tx_data,
  input wire logic [1:0] i_tx_lanes,
  input wire logic i_tx_last,
  input wire logic [PORT_W-1:0] i_tx_port,
  output logic o_tx_ready,
  output logic o_tx_done,
  output logic [TXQ_AW:0] o_tx_free,
  // Transmit queue drain toward a MAC.
  input wire logic [NUM_PORTS-1:0] i_mac_tx_ready,
  output logic [NUM_PORTS-1:0] o_mac_tx_valid,
  output logic [31:0] o_mac_tx_data,
  output logic o_mac_tx_last,
  // Receive words from the MACs.
  input wire logic [NUM_PORTS-1:0] i_mac_rx_valid,
  input wire logic [31:0] i_mac_rx_data,
  input wire logic [NUM_PORTS-1:0] i_mac_rx_last,
  output logic [NUM_PORTS-1:0] o_mac_rx_ready,
  output logic o_rx_note,
  output logic [SRAM_AW-1:0] o_rx_len,
  // Burst read of SRAM toward the host.
  input wire logic i_up_req,
  input wire logic i_up_ready,
  output logic o_up_valid,
  output logic [31:0] o_up_data,
  output logic o_up_last,
  // Single word access.
  input wire logic i_acc_req,
  input wire logic i_acc_wr,
  input wire logic [1:0] i_acc_sel,
  input wire logic [PORT_W-1:0] i_acc_port,
  input wire logic [SRAM_AW-1:0] i_acc_addr,
  input wire logic [31:0] i_acc_wdata,
  output logic o_acc_ack,
  output logic [31:0] o_acc_rdata,
  // Configuration stream.
  input wire logic i_cfg_full,
  output logic o_cfg_wr,
  output logic [31:0] o_cfg_data
);
  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rstn = rst_s2_r;  // [RULE17]

  // Reverse byte order of a word when the host order differs.
  function automatic logic [31:0] swap_w(input logic [31:0] w,
                                         input logic en);
    swap_w = en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;  // [RULE12]
  endfunction : swap_w

  // ****************************************************************
  // Two-entry input buffer on the DMA path
  // ****************************************************************
  logic [34:0] ib_mem [2];
  logic [PORT_W-1:0] ib_port [2];
  logic ib_wp_r, ib_rp_r;
  logic [1:0] ib_cnt_r;
  wire dma_ok = !i_user_mode;  // [RULE16]
  wire ib_push = i_tx_valid && o_tx_ready;
  wire ib_valid = ib_cnt_r != 2'h0;
  wire [34:0] ib_head = ib_mem[ib_rp_r];
  wire [PORT_W-1:0] ib_hport = ib_port[ib_rp_r];
  logic ib_pop;
  assign o_tx_ready = dma_ok && ib_cnt_r != 2'h2;  // [RULE4]
  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) begin
      ib_wp_r <= 1'b0;
      ib_rp_r <= 1'b0;
      ib_cnt_r <= 2'h0;
    end else if (i_ce) begin
      if (ib_push) ib_wp_r <= ~ib_wp_r;
      if (ib_pop) ib_rp_r <= ~ib_rp_r;
      ib_cnt_r <= ib_cnt_r + {1'b0, ib_push} - {1'b0, ib_pop};
    end
  end
  // Buffer storage; the byte swap is applied on entry.
  always_ff @(posedge i_sys_clk) begin
    if (i_ce && ib_push) begin
      ib_mem[ib_wp_r] <= {i_tx_last, i_tx_lanes,
                          swap_w(i_tx_data, i_swap_en)};  // [RULE12]
      ib_port[ib_wp_r] <= i_tx_port;
    end
  end

  // ****************************************************************
  // Port transmit queues
  // ****************************************************************
  // Entry keeps last flag and data; lanes pass untouched in low bytes.
  logic [32:0] txq [NUM_PORTS][TXQ_DEPTH];
  logic [TXQ_AW:0] tx_wp_r [NUM_PORTS];
  logic [TXQ_AW:0] tx_rp_r [NUM_PORTS];
  logic [NUM_PORTS-1:0] tx_full, tx_empty, tx_wr, tx_rd;
  logic [NUM_PORTS-1:0] diag_tx_wr, diag_tx_rd, diag_rx_rd;
  logic [PORT_W-1:0] mac_sel;
  logic tx_done_r;
  wire acc_ok = i_acc_req && !o_acc_ack;
  wire [TXQ_AW:0] free_of = (TXQ_AW+1)'(TXQ_DEPTH)
                   - (tx_wp_r[i_tx_port] - tx_rp_r[i_tx_port]);
  assign o_tx_free = free_of;  // [RULE1]
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_tx
      assign tx_full[p] = (tx_wp_r[p] - tx_rp_r[p]) ==
                          (TXQ_AW+1)'(TXQ_DEPTH);
      assign tx_empty[p] = tx_wp_r[p] == tx_rp_r[p];
      assign diag_tx_wr[p] = acc_ok && i_acc_wr && i_acc_sel == ACC_TXQ
                          && i_acc_port == PORT_W'(p) && !tx_full[p];
      assign diag_tx_rd[p] = acc_ok && !i_acc_wr && i_acc_sel == ACC_TXQ
                          && i_acc_port == PORT_W'(p) && !tx_empty[p];
      assign tx_wr[p] = ib_pop && ib_hport == PORT_W'(p);
      assign o_mac_tx_valid[p] = !tx_empty[p];
      assign tx_rd[p] = (!tx_empty[p] && i_mac_tx_ready[p]
                         && mac_sel == PORT_W'(p)) || diag_tx_rd[p];
      always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
          tx_wp_r[p] <= '0;
          tx_rp_r[p] <= '0;
        end else if (i_ce) begin
          if (tx_wr[p] || diag_tx_wr[p]) tx_wp_r[p] <= tx_wp_r[p] + 1'b1;
          if (tx_rd[p]) tx_rp_r[p] <= tx_rp_r[p] + 1'b1;
        end
      end
      always_ff @(posedge i_sys_clk) begin
        if (i_ce && tx_wr[p])
          txq[p][tx_wp_r[p][TXQ_AW-1:0]] <= {ib_head[34], ib_head[31:0]};
        else if (i_ce && diag_tx_wr[p])
          txq[p][tx_wp_r[p][TXQ_AW-1:0]] <= {1'b1, i_acc_wdata};  // [RULE9]
      end
    end
  endgenerate
  // DMA wins the queue over a diagnostic write in the same cycle.
  assign ib_pop = ib_valid && !tx_full[ib_hport];
  // Lowest ready port drains; data shown is that port's head.
  always_comb begin
    mac_sel = '0;
    for (int p = NUM_PORTS-1; p >= 0; p--)
      if (!tx_empty[p] && i_mac_tx_ready[p]) mac_sel = PORT_W'(p);
  end
  assign o_mac_tx_data = txq[mac_sel][tx_rp_r[mac_sel][TXQ_AW-1:0]][31:0];
  assign o_mac_tx_last = txq[mac_sel][tx_rp_r[mac_sel][TXQ_AW-1:0]][32];
  // Completion pulse after the last word of a packet enters its queue.
  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) tx_done_r <= 1'b0;
    else if (i_ce) tx_done_r <= ib_pop && ib_head[34];  // [RULE3] [RULE13]
  end
  assign o_tx_done = tx_done_r;

  // ****************************************************************
  // Port receive queues
  // ****************************************************************
  logic [32:0] rxq [NUM_PORTS][RXQ_DEPTH];
  logic [RXQ_AW:0] rx_wp_r [NUM_PORTS];
  logic [RXQ_AW:0] rx_rp_r [NUM_PORTS];
  logic [RXQ_AW:0] rx_pk_r [NUM_PORTS];
  logic [NUM_PORTS-1:0] rx_full, rx_empty, rx_has_pkt, rx_rd, rx_wr;
  logic [PORT_W-1:0] grant_r, next_grant;
  arb_state_t arb_r;
  logic arb_move;
  wire [PORT_W-1:0] vport = i_vmac[PORT_W-1:0];
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_rx
      // Virtual MAC numbers pick a queue in user mode; port 0 is live.
      wire live = !i_user_mode || p == 0;  // [RULE15]
      wire vsel = i_user_mode ? vport == PORT_W'(p) : 1'b1;
      wire src_v = i_user_mode ? i_mac_rx_valid[0] : i_mac_rx_valid[p];
      wire src_l = i_user_mode ? i_mac_rx_last[0] : i_mac_rx_last[p];
      assign rx_full[p] = (rx_wp_r[p] - rx_rp_r[p]) ==
                          (RXQ_AW+1)'(RXQ_DEPTH);
      assign rx_empty[p] = rx_wp_r[p] == rx_rp_r[p];
      assign rx_has_pkt[p] = rx_pk_r[p] != '0;
      assign rx_wr[p] = src_v && vsel && !rx_full[p];  // [RULE5]
      assign o_mac_rx_ready[p] = live && (i_user_mode
                                 ? !rx_full[vport] : !rx_full[p]);
      assign diag_rx_rd[p] = acc_ok && !i_acc_wr && i_acc_sel == ACC_RXQ
                          && i_acc_port == PORT_W'(p) && !rx_empty[p];
      assign rx_rd[p] = (arb_move && grant_r == PORT_W'(p)) ||
                        (diag_rx_rd[p] && arb_r == ARB_IDLE);
      wire pk_in = rx_wr[p] && src_l;
      wire pk_out = rx_rd[p] && rxq[p][rx_rp_r[p][RXQ_AW-1:0]][32];
      always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
          rx_wp_r[p] <= '0;
          rx_rp_r[p] <= '0;
          rx_pk_r[p] <= '0;
        end else if (i_ce) begin
          if (rx_wr[p]) rx_wp_r[p] <= rx_wp_r[p] + 1'b1;
          if (rx_rd[p]) rx_rp_r[p] <= rx_rp_r[p] + 1'b1;
          rx_pk_r[p] <= rx_pk_r[p] + {{RXQ_AW{1'b0}}, pk_in}
                        - {{RXQ_AW{1'b0}}, pk_out};
        end
      end
      always_ff @(posedge i_sys_clk) begin
        if (i_ce && rx_wr[p])  // [RULE11]
          rxq[p][rx_wp_r[p][RXQ_AW-1:0]] <= {src_l, i_mac_rx_data};
      end
    end
  endgenerate

  // ****************************************************************
  // Receive arbiter into SRAM
  // ****************************************************************
  logic [31:0] sram [SRAM_DEPTH];
  logic [SRAM_AW-1:0] s_wa_r, s_len_r;
  logic note_r;
  wire [32:0] rx_head = rxq[grant_r][rx_rp_r[grant_r][RXQ_AW-1:0]];
  // Search from the port after the last grant.
  always_comb begin
    next_grant = grant_r;
    for (int k = NUM_PORTS; k >= 1; k--)
      if (rx_has_pkt[PORT_W'(grant_r + PORT_W'(k))])
        next_grant = PORT_W'(grant_r + PORT_W'(k));  // [RULE19]
  end
  assign arb_move = arb_r == ARB_MOVE && !rx_empty[grant_r];
  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) begin
      arb_r <= ARB_IDLE;
      grant_r <= '0;
      s_wa_r <= '0;
      note_r <= 1'b0;
    end else if (i_ce) begin
      note_r <= 1'b0;
      case (arb_r)
        ARB_IDLE: begin
          if (|rx_has_pkt && !i_up_req) begin
            grant_r <= next_grant;
            s_wa_r <= '0;
            arb_r <= ARB_MOVE;
          end
        end
        ARB_MOVE: begin
          if (arb_move) begin
            s_wa_r <= s_wa_r + 1'b1;
            if (rx_head[32]) arb_r <= ARB_NOTE;  // [RULE6]
          end
        end
        ARB_NOTE: begin
          note_r <= 1'b1;  // [RULE6]
          arb_r <= ARB_IDLE;
        end
        default: arb_r <= ARB_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_ce && arb_move) sram[s_wa_r] <= rx_head[31:0];  // [RULE14]
  end
  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) s_len_r <= '0;
    else if (i_ce && arb_r == ARB_NOTE) s_len_r <= s_wa_r;
  end
  assign o_rx_note = note_r;
  assign o_rx_len = s_len_r;

  // ****************************************************************
  // SRAM to host burst path
  // ****************************************************************
  logic [31:0] up_buf [BURST_WORDS];
  logic [SRAM_AW-1:0] up_ra_r;
  logic [2:0] up_fill_r, up_out_r;
  logic up_go_r;
  wire up_en = i_up_req && dma_ok && arb_r == ARB_IDLE;
  wire up_fill = up_en && !up_go_r && up_fill_r != 3'(BURST_WORDS);
  // Burst starts only after a full burst is buffered.
  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) begin
      up_ra_r <= '0;
      up_fill_r <= '0;
      up_out_r <= '0;
      up_go_r <= 1'b0;
    end else if (i_ce) begin
      if (!i_up_req) begin
        up_ra_r <= '0;
        up_fill_r <= '0;
        up_go_r <= 1'b0;
      end else if (up_fill) begin
        up_ra_r <= up_ra_r + 1'b1;
        up_fill_r <= up_fill_r + 1'b1;
        if (up_fill_r == 3'(BURST_WORDS - 1)) up_go_r <= 1'b1;  // [RULE8]
        up_out_r <= '0;
      end else if (up_go_r && i_up_ready) begin
        up_out_r <= up_out_r + 1'b1;
        if (up_out_r == 3'(BURST_WORDS - 1)) begin
          up_go_r <= 1'b0;
          up_fill_r <= '0;
        end
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_ce && up_fill)
      up_buf[up_fill_r[1:0]] <= swap_w(sram[up_ra_r], i_swap_en);
  end
  assign o_up_valid = up_go_r;
  assign o_up_data = up_buf[up_out_r[1:0]];
  assign o_up_last = up_go_r && (up_ra_r - s_len_r) < SRAM_AW'(BURST_WORDS)
                     && up_out_r == 3'(BURST_WORDS - 1);

  // ****************************************************************
  // Single word access and configuration stream
  // ****************************************************************
  logic ack_r, cfg_wr_r;
  logic [31:0] rdata_r, cfg_r;
  wire [31:0] rd_mux =
    i_acc_sel == ACC_TXQ ? txq[i_acc_port][tx_rp_r[i_acc_port][TXQ_AW-1:0]]
                           [31:0] :
    i_acc_sel == ACC_RXQ ? rxq[i_acc_port][rx_rp_r[i_acc_port][RXQ_AW-1:0]]
                           [31:0] :
    i_acc_sel == ACC_SRAM ? sram[i_acc_addr] : WORD_RST;
  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      rdata_r <= WORD_RST;
      cfg_wr_r <= 1'b0;
      cfg_r <= WORD_RST;
    end else if (i_ce) begin
      ack_r <= acc_ok;  // [RULE10]
      if (acc_ok && !i_acc_wr) rdata_r <= rd_mux;  // [RULE9]
      cfg_wr_r <= acc_ok && i_acc_wr && i_acc_sel == ACC_CFG
                  && !i_cfg_full;  // [RULE18]
      if (acc_ok && i_acc_wr && i_acc_sel == ACC_CFG) cfg_r <= i_acc_wdata;
    end
  end
  assign o_acc_ack = ack_r;
  assign o_acc_rdata = rdata_r;
  assign o_cfg_wr = cfg_wr_r;
  assign o_cfg_data = cfg_r;
endmodule : host_mac_packet_path

/* dv/host_mac_packet_path_chk.sv */
// Port timing checker for the packet path.
`timescale 1ns/1ps
module host_mac_packet_path_chk
  import pkt_path_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_user_mode,
  input wire logic i_tx_valid,
  input wire logic i_tx_last,
  input wire logic o_tx_ready,
  input wire logic o_tx_done,
  input wire logic [TXQ_AW:0] o_tx_free,
  input wire logic i_up_req,
  input wire logic i_up_ready,
  input wire logic o_up_valid,
  input wire logic [31:0] o_up_data,
  input wire logic o_up_last,
  input wire logic i_acc_req,
  input wire logic i_acc_wr,
  input wire logic [1:0] i_acc_sel,
  input wire logic o_acc_ack,
  input wire logic i_cfg_full,
  input wire logic o_cfg_wr,
  input wire logic o_rx_note,
  input wire logic [SRAM_AW-1:0] o_rx_len
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // Access taken, and a configuration write among them.
  wire logic acc_take = i_acc_req && !o_acc_ack && i_ce;
  wire logic cfg_go = acc_take && i_acc_wr && (i_acc_sel == ACC_CFG);
  wire logic last_in = i_tx_valid && o_tx_ready && i_ce && i_tx_last;
  property p_user; i_user_mode |-> !o_tx_ready; endproperty
  a_user: assert property (p_user)
    else $error("tx ready high in user mode");
  property p_done; last_in && o_tx_free > 5'h01 |-> ##[2:3] o_tx_done;
  endproperty
  a_done: assert property (p_done)
    else $error("no done after last word");
  property p_ack; acc_take |=> o_acc_ack; endproperty
  a_ack: assert property (p_ack)
    else $error("access not acknowledged");
  property p_ack1; o_acc_ack |=> !o_acc_ack; endproperty
  a_ack1: assert property (p_ack1)
    else $error("ack longer than one cycle");
  property p_hold;
    o_up_valid && !i_up_ready && i_up_req |=> o_up_valid && $stable(o_up_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("burst word changed while stalled");
  property p_start; $rose(o_up_valid) |-> $past(i_up_req); endproperty
  a_start: assert property (p_start)
    else $error("burst started without request");
  property p_cfg; cfg_go && !i_cfg_full |-> ##[1:2] o_cfg_wr; endproperty
  a_cfg: assert property (p_cfg)
    else $error("configuration word not emitted");
  property p_cfg_drop; cfg_go && i_cfg_full |=> !o_cfg_wr [*2]; endproperty
  a_cfg_drop: assert property (p_cfg_drop)
    else $error("configuration word emitted while full");
  property p_note; o_rx_note |-> (o_rx_len != 8'h00) ##1 !o_rx_note;
  endproperty
  a_note: assert property (p_note)
    else $error("bad receive notification");
  c_done: cover property (o_tx_done);
  c_note: cover property (o_rx_note);
  c_burst: cover property (o_up_valid && i_up_ready && o_up_last);
endmodule : host_mac_packet_path_chk
bind host_mac_packet_path host_mac_packet_path_chk u_chk (.*);

/* dv/mac_port_model.sv */
// Behavioural model of the four MAC ports beside the packet path.
`timescale 1ns/1ps
module mac_port_model (
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic [1:0] i_port,
  input wire logic [7:0] i_len,
  input wire logic i_stall,
  input wire logic [3:0] i_rx_ready,
  output logic o_busy,
  output logic [3:0] o_rx_valid,
  output logic [31:0] o_rx_data,
  output logic [3:0] o_rx_last,
  output logic [3:0] o_tx_ready
);
  // ****************************************************************
  // Packet sender
  // ****************************************************************
  logic [1:0] port_r = 2'h0;
  logic [7:0] len_r = 8'h00;
  logic [7:0] idx_r = 8'h00;
  logic [31:0] prev_r = 32'h0000_0000;
  logic busy_r = 1'b0;
  // Idle data lines show the inverse of the last word, never stale data.
  wire logic [31:0] word = {6'h00, port_r, 8'ha5, 8'h00, idx_r};
  wire logic fin = busy_r && (idx_r == len_r - 8'h01);
  assign o_busy = busy_r;
  assign o_rx_valid = busy_r ? 4'h1 << port_r : 4'h0;
  assign o_rx_last = fin ? 4'h1 << port_r : 4'h0;
  assign o_rx_data = busy_r ? word : ~prev_r;
  assign o_tx_ready = i_stall ? 4'h0 : 4'hf;
  // Each word is held until its queue takes it.
  always @(posedge i_clk) begin
    if (i_send && !busy_r) begin
      port_r <= i_port;
      len_r <= i_len;
      idx_r <= 8'h00;
      busy_r <= 1'b1;
    end else if (busy_r && i_rx_ready[port_r]) begin
      prev_r <= word;
      idx_r <= idx_r + 8'h01;
      busy_r <= !fin;
    end
  end
endmodule : mac_port_model

/* dv/host_mac_packet_path_bench.sv */
// Self-checking testbench of the packet path.
`timescale 1ns/1ps
module host_mac_packet_path_bench;
  import pkt_path_pkg::*;
  logic i_sys_clk = 0, i_rstn = 0, i_ce = 1, i_swap_en = 0, i_user_mode = 0;
  logic [2:0] i_vmac = 3'h0;
  logic i_tx_valid = 0, i_tx_last = 0, i_up_req = 0, i_up_ready = 0;
  logic i_acc_req = 0, i_acc_wr = 0, i_cfg_full = 0, snd = 0, stall = 1;
  logic [1:0] i_tx_lanes = 0, i_tx_port = 0, i_acc_sel = 0, i_acc_port = 0;
  logic [1:0] sport = 0;
  logic [7:0] slen = 0, i_acc_addr = 0, o_rx_len;
  logic [31:0] i_tx_data = 0, i_acc_wdata = 0, o_mac_tx_data, i_mac_rx_data;
  logic [31:0] o_up_data, o_acc_rdata, o_cfg_data, cfg_d;
  logic [3:0] i_mac_tx_ready, o_mac_tx_valid, i_mac_rx_valid;
  logic [3:0] i_mac_rx_last, o_mac_rx_ready;
  logic [TXQ_AW:0] o_tx_free;
  logic o_tx_ready, o_tx_done, o_mac_tx_last, o_rx_note, o_up_valid;
  logic o_up_last, o_acc_ack, o_cfg_wr, busy;
  int miscompares = 0, n_compared = 0, cfg_n = 0;
  host_mac_packet_path dut (.*);
  mac_port_model mac (.i_clk(i_sys_clk), .i_send(snd), .i_port(sport),
    .i_len(slen), .i_stall(stall), .i_rx_ready(o_mac_rx_ready),
    .o_busy(busy), .o_rx_valid(i_mac_rx_valid), .o_rx_data(i_mac_rx_data),
    .o_rx_last(i_mac_rx_last), .o_tx_ready(i_mac_tx_ready));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Clock, and a log of configuration words leaving the block.
  always #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_cfg_wr) begin
    cfg_n++;
    cfg_d = o_cfg_data;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tk
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] pat(logic [1:0] p, int k);
    return {6'h00, p, 8'ha5, 8'h00, 8'(k)};
  endfunction : pat
  task automatic acc(logic wr, logic [1:0] sel, logic [7:0] ad, logic [31:0] d);
    int t;
    {i_acc_wr, i_acc_sel, i_acc_port, i_acc_addr} = {wr, sel, 2'h3, ad};
    i_acc_wdata = d;
    i_acc_req = 1'b1;
    for (t = 0; t < 3 && !o_acc_ack; t++) tk(1);
    chk("ack", 32'(o_acc_ack), 32'd1);
    tk(1);
    i_acc_req = 1'b0;
    tk(1);
  endtask : acc
  task automatic send(logic [1:0] p, logic [7:0] n);
    {sport, slen, snd} = {p, n, 1'b1};
    tk(1);
    snd = 1'b0;
    for (int t = 0; t < 100 && busy; t++) tk(1);
  endtask : send
  task automatic wnote(logic [7:0] n);
    for (int t = 0; t < 200 && !o_rx_note; t++) tk(1);
    chk("rx len", 32'(o_rx_len), 32'(n));
    tk(1);
  endtask : wnote
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_tx(logic [1:0] p, logic s);
    logic [31:0] w, m;
    int t;
    {i_tx_port, i_swap_en, stall} = {p, s, 1'b1};
    tk(1);
    for (t = 0; t < DRAIN_CYC && o_tx_free < 5'h03; t++) tk(1);
    chk("tx free", 32'(o_tx_free), 32'd16);
    for (int k = 0; k < 3; k++) begin
      i_tx_data = 32'h0302_0100 + 32'(k) * 32'h0404_0404;
      {i_tx_last, i_tx_valid} = {k == 2, 1'b1};
      for (t = 0; t < 20 && !o_tx_ready; t++) tk(1);
      tk(1);
    end
    {i_tx_last, i_tx_valid} = 2'b00;
    for (t = 0; t < 4 && !o_tx_done; t++) tk(1);
    chk("tx done", 32'(o_tx_done), 32'd1);
    chk("tx free", 32'(o_tx_free), 32'd13);
    stall = 1'b0;
    tk(0);
    for (int k = 0; k < 3; k++) begin
      w = 32'h0302_0100 + 32'(k) * 32'h0404_0404;
      if (s) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
      m = (k == 2) ? 32'h0000_00ff : 32'hffff_ffff;
      chk("mac valid", 32'(o_mac_tx_valid[p]), 32'd1);
      chk("mac data", o_mac_tx_data & m, w & m);
      chk("mac last", 32'(o_mac_tx_last), 32'(k == 2));
      tk(1);
    end
    chk("mac valid", 32'(o_mac_tx_valid[p]), 32'd0);
    {stall, i_swap_en} = 2'b10;
  endtask : t_tx
  task automatic t_user;
    {i_user_mode, i_tx_valid, i_vmac} = 5'h1a;
    tk(2);
    chk("tx ready", 32'(o_tx_ready), 32'd0);
    chk("tx free", 32'(o_tx_free), 32'd16);
    send(2'h0, 8'd2);
    wnote(8'd2);
    chk("rx ready", 32'(o_mac_rx_ready), 32'h1);
    {i_user_mode, i_tx_valid, i_vmac} = 5'h00;
    tk(1);
  endtask : t_user
  task automatic t_rx;
    int k, t;
    send(2'h1, 8'd2);
    wnote(8'd2);
    i_up_req = 1'b1;
    send(2'h0, 8'd4);
    send(2'h2, 8'd3);
    i_up_req = 1'b0;
    wnote(8'd3);
    wnote(8'd4);
    i_up_req = 1'b1;
    for (k = 0, t = 0; k < 4 && t < 100; t++) begin
      i_up_ready = t[0];
      if (o_up_valid && i_up_ready) begin
        chk("up data", o_up_data, pat(2'h0, k));
        chk("up last", 32'(o_up_last), 32'(k == 3));
        k++;
      end
      tk(1);
    end
    chk("up words", 32'(k), 32'd4);
    {i_up_req, i_up_ready} = 2'b00;
    tk(2);
  endtask : t_rx
  task automatic t_acc;
    acc(1'b1, ACC_TXQ, 8'h00, 32'hcafe_0123);
    tk(1);
    chk("diag push", 32'(o_mac_tx_valid[3]), 32'd1);
    acc(1'b0, ACC_TXQ, 8'h00, 32'h0);
    chk("diag pop", o_acc_rdata, 32'hcafe_0123);
    acc(1'b0, ACC_SRAM, 8'h01, 32'h0);
    chk("sram read", o_acc_rdata, pat(2'h0, 1));
    i_up_req = 1'b1;
    send(2'h3, 8'd1);
    acc(1'b0, ACC_RXQ, 8'h00, 32'h0);
    chk("rx diag", o_acc_rdata, pat(2'h3, 0));
    i_up_req = 1'b0;
    acc(1'b1, ACC_CFG, 8'h00, 32'h1234_5678);
    tk(2);
    chk("cfg count", 32'(cfg_n), 32'd1);
    chk("cfg data", cfg_d, 32'h1234_5678);
    i_cfg_full = 1'b1;
    acc(1'b1, ACC_CFG, 8'h00, 32'h0bad_0001);
    tk(2);
    chk("cfg count", 32'(cfg_n), 32'd1);
    i_cfg_full = 1'b0;
  endtask : t_acc
  task automatic summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // Main sequence after a 20 cycle reset.
  initial begin
    tk(20);
    i_rstn = 1'b1;
    tk(3);
    t_tx(2'h0, 1'b0);
    t_tx(2'h3, 1'b1);
    t_user;
    t_rx;
    t_acc;
    summarize;
  end
  // Watchdog well beyond the hundred or so cycles the scenarios need.
  initial begin
    #500000;
    miscompares++;
    summarize;
  end
endmodule : host_mac_packet_path_bench
